// >>> design/ddsc_mode_clk_cfg.sv
// Notes on behaviour
// - Reset leaves both channels single-tone
// - Shared tuning/phase address, enabled channels only
// - Channel enables act on select byte write
// - Both channel enables set at reset
// - Reset: single-bit serial, words cleared
// - New words drive outputs after commit
// - Matched bit equalises latency, single-tone only
// - Multiplier field is bits 22:18, reg one
// - Multiplier 4..20 enables PLL times value
// - Otherwise bypass, factor one
// - VCO gain bit resets to low range
// - Charge pump resets to 75 uA
// - Mode pin high: crystal; low: buffer
// - Bits 9:8 scale each DAC current
// - Sweep bit 14 set ends single-tone on that channel
// - Commit on strobe rise at sync tick
// - Sync clock is quarter rate, can stop
`timescale 1ns/1ps
module ddsc_mode_clk_cfg #(
    parameter int unsigned LOCK_CYC = ddsc_pkg::PLL_LOCK_CYC
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // Serial port pins
    input  wire logic              spi_cs_n,
    input  wire logic              spi_sclk,
    input  wire logic              spi_sdio0_i,
    output logic                   spi_sdio0_o,
    output logic                   spi_sdio0_oe,
    // Strobe and clock pins
    input  wire logic              io_update,
    input  wire logic              clk_mode_sel,
    output logic                   sync_clk,
    // Channel outputs
    output logic [1:0][31:0]       tuning_word_out,
    output logic [1:0][15:0]       phase_offset_word_out,
    output logic [1:0][1:0]        dac_scale,
    output logic [1:0]             single_tone,
    output logic [1:0]             matched_delay,
    // Configuration outputs
    output logic [1:0]             serial_mode,
    output ddsc_pkg::ddsc_clk_s    clk_cfg
);
    typedef struct packed {
        logic [4:0]                     meta;
        logic [4:0]                     pins;
        logic                           sclk_prev;
        ddsc_pkg::ddsc_spi_e            st;
        logic [5:0]                     bits;
        logic                           rd;
        logic [4:0]                     addr;
        logic [31:0]                    sr;
        logic [31:0]                    rdsr;
        logic                           sdo;
        logic                           sdo_oe;
        logic [7:0]                     csel;
        logic [23:0]                    fr1_buf;
        logic [23:0]                    fr1_act;
        ddsc_pkg::ddsc_chan_s [1:0]     stage;
        ddsc_pkg::ddsc_chan_s [1:0]     act;
        logic [1:0]                     tone;
        logic [1:0]                     match;
        logic [1:0][1:0]                dac;
        ddsc_pkg::ddsc_clk_s            clk;
        logic [17:0]                    lock_cnt;
    } ddsc_core_s;

    function automatic ddsc_core_s core_rst();
        ddsc_core_s r;
        r = '0;
        r.meta[ddsc_pkg::PIN_CS] = 1'b1;
        r.pins[ddsc_pkg::PIN_CS] = 1'b1;
        r.st       = ddsc_pkg::SP_INSTR;
        r.bits     = ddsc_pkg::INSTR_BITS;
        r.csel     = ddsc_pkg::CSEL_RST;
        r.fr1_buf  = ddsc_pkg::FR1_RST;
        r.fr1_act  = ddsc_pkg::FR1_RST;
        r.stage    = {ddsc_pkg::CHAN_RST, ddsc_pkg::CHAN_RST};
        r.act      = {ddsc_pkg::CHAN_RST, ddsc_pkg::CHAN_RST};
        r.tone     = 2'h3;
        r.dac[0]   = ddsc_pkg::CFR_RST[ddsc_pkg::CFR_DAC_LSB +: 2];
        r.dac[1]   = ddsc_pkg::CFR_RST[ddsc_pkg::CFR_DAC_LSB +: 2];
        r.clk.mult = ddsc_pkg::MULT_ONE;
        r.clk.sync_en    = 1'b1;
        r.clk.pll_locked = 1'b1;
        return r;
    endfunction

    localparam ddsc_core_s  CORE_RST = core_rst();
    localparam logic [17:0] LOCK18   = 18'(LOCK_CYC);

    ddsc_core_s  q;
    ddsc_core_s  d;
    logic        commit;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        wr_en;
    logic        chp;
    logic [31:0] shin;
    logic [31:0] rdval;
    logic [4:0]  mfield;
    logic [1:0]  phase_tap [2];

    // Sync clock and commit sampling
    ddsc_sync_gen u_sync (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .sync_en  (q.clk.sync_en),
        .upd_lvl  (q.pins[ddsc_pkg::PIN_UPD]),
        .sync_clk (sync_clk),
        .commit   (commit)
    );

    always_comb begin
        d = q;
        wr_en = 1'b0;
        // Pin synchronisers
        d.meta      = {clk_mode_sel, io_update, spi_sdio0_i, spi_sclk, spi_cs_n};
        d.pins      = q.meta;
        d.sclk_prev = q.pins[ddsc_pkg::PIN_SCLK];
        sclk_rise   = q.pins[ddsc_pkg::PIN_SCLK] & ~q.sclk_prev;
        sclk_fall   = ~q.pins[ddsc_pkg::PIN_SCLK] & q.sclk_prev;
        shin        = {q.sr[30:0], q.pins[ddsc_pkg::PIN_SDI]};
        chp         = ~q.csel[ddsc_pkg::CSEL_EN0_BIT];
        // Read word, left aligned
        case (shin[4:0])
            ddsc_pkg::ADDR_CSEL:  rdval = {q.csel, 24'h000000};
            ddsc_pkg::ADDR_FR1:   rdval = {q.fr1_buf, 8'h00};
            ddsc_pkg::ADDR_CFR:   rdval = {q.stage[chp].channel_function_reg, 8'h00};
            ddsc_pkg::ADDR_TUNE:  rdval = q.stage[chp].tune;
            ddsc_pkg::ADDR_PHASE: rdval = {q.stage[chp].phase, 16'h0000};
            default:              rdval = 32'h00000000;
        endcase
        // Serial port, single-bit mode
        if (q.pins[ddsc_pkg::PIN_CS]) begin
            d.st     = ddsc_pkg::SP_INSTR;
            d.bits   = ddsc_pkg::INSTR_BITS;
            d.sdo_oe = 1'b0;
        end else begin
            if (sclk_rise) begin
                d.sr   = shin;
                d.bits = q.bits - 6'h01;
                if (q.bits == 6'h01) begin
                    d.st   = ddsc_pkg::SP_INSTR;
                    d.bits = ddsc_pkg::INSTR_BITS;
                    case (q.st)
                        ddsc_pkg::SP_INSTR: begin
                            d.rd   = shin[7];
                            d.addr = shin[4:0];
                            d.rdsr = rdval;
                            if (ddsc_pkg::reg_bytes(shin[4:0]) == 3'h0) begin
                                d.st = ddsc_pkg::SP_SKIP;
                            end else begin
                                d.st   = ddsc_pkg::SP_DATA;
                                d.bits = {ddsc_pkg::reg_bytes(shin[4:0]), 3'b000};
                            end
                        end
                        ddsc_pkg::SP_DATA: begin
                            wr_en = ~q.rd;
                        end
                        default: begin
                            d.st = ddsc_pkg::SP_INSTR;
                        end
                    endcase
                end
            end
            if (sclk_fall && q.st == ddsc_pkg::SP_DATA && q.rd) begin
                d.sdo    = q.rdsr[31];
                d.rdsr   = {q.rdsr[30:0], 1'b0};
                d.sdo_oe = 1'b1;
            end
            if (q.st != ddsc_pkg::SP_DATA) begin
                d.sdo_oe = 1'b0;
            end
        end
        // Register writes
        if (wr_en) begin
            case (q.addr)
                ddsc_pkg::ADDR_CSEL: begin
                    d.csel = shin[7:0];
                end
                ddsc_pkg::ADDR_FR1: begin
                    d.fr1_buf = shin[23:0];
                end
                ddsc_pkg::ADDR_CFR: begin
                    for (int ch = 0; ch < 2; ch++) begin
                        if (q.csel[ddsc_pkg::CSEL_EN0_BIT + ch]) begin
                            d.stage[ch].channel_function_reg = shin[23:0];
                        end
                    end
                end
                ddsc_pkg::ADDR_TUNE: begin
                    for (int ch = 0; ch < 2; ch++) begin
                        if (q.csel[ddsc_pkg::CSEL_EN0_BIT + ch]) begin
                            d.stage[ch].tune = shin;
                        end
                    end
                end
                ddsc_pkg::ADDR_PHASE: begin
                    for (int ch = 0; ch < 2; ch++) begin
                        if (q.csel[ddsc_pkg::CSEL_EN0_BIT + ch]) begin
                            d.stage[ch].phase = shin[15:0];
                        end
                    end
                end
                default: begin
                    d.csel = q.csel;
                end
            endcase
        end
        // Commit staged words
        if (commit) begin
            d.act     = q.stage;
            d.fr1_act = q.fr1_buf;
        end
        // Channel modes
        for (int ch = 0; ch < 2; ch++) begin
            d.tone[ch]  = (q.act[ch].channel_function_reg[ddsc_pkg::CFR_AFP_LSB +: 2] == 2'h0)
                        & ~q.act[ch].channel_function_reg[ddsc_pkg::CFR_SWEEP_BIT];
            d.match[ch] = q.act[ch].channel_function_reg[ddsc_pkg::CFR_MATCH_BIT] & d.tone[ch];
            d.dac[ch]   = q.act[ch].channel_function_reg[ddsc_pkg::CFR_DAC_LSB +: 2];
        end
        // Clock configuration
        mfield           = q.fr1_act[ddsc_pkg::FR1_MULT_LSB +: 5];
        d.clk.pll_en     = ddsc_pkg::mult_valid(mfield);
        d.clk.mult       = d.clk.pll_en ? mfield : ddsc_pkg::MULT_ONE;
        d.clk.vco_high   = q.fr1_act[ddsc_pkg::FR1_VCO_BIT];
        d.clk.cp_sel     = q.fr1_act[ddsc_pkg::FR1_CP_LSB +: 2];
        d.clk.xtal_en    = q.pins[ddsc_pkg::PIN_CMS];
        d.clk.sync_en    = ~q.fr1_act[ddsc_pkg::FR1_SYNC_DIS_BIT];
        if (d.clk.pll_en != q.clk.pll_en || d.clk.mult != q.clk.mult) begin
            d.lock_cnt = 18'h00000;
        end else if (q.lock_cnt != LOCK18) begin
            d.lock_cnt = q.lock_cnt + 18'h00001;
        end
        d.clk.pll_locked = ~d.clk.pll_en | (d.lock_cnt == LOCK18);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q <= CORE_RST;
        end else begin
            q <= d;
        end
    end

    // Output pipelines
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        assign phase_tap[ch] = q.match[ch] ? ddsc_pkg::FREQ_TAP : ddsc_pkg::PHASE_TAP;

        ddsc_delay_line #(.W(32)) u_tune (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .din     (q.act[ch].tune),
            .tap     (ddsc_pkg::FREQ_TAP),
            .dout    (tuning_word_out[ch])
        );

        ddsc_delay_line #(.W(16)) u_phase (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .din     (q.act[ch].phase),
            .tap     (phase_tap[ch]),
            .dout    (phase_offset_word_out[ch])
        );
    end

    assign spi_sdio0_o   = q.sdo;
    assign spi_sdio0_oe  = q.sdo_oe;
    assign dac_scale     = q.dac;
    assign single_tone   = q.tone;
    assign matched_delay = q.match;
    assign serial_mode   = q.csel[ddsc_pkg::CSEL_MODE_LSB +: 2];
    assign clk_cfg       = q.clk;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    chk_csel_write_only: assert property (
        $changed(q.csel) |-> $past(wr_en && q.addr == ddsc_pkg::ADDR_CSEL))
        else $error("channel select changed without a write");

    chk_commit_copy: assert property (
        commit |=> q.act == $past(q.stage) && q.fr1_act == $past(q.fr1_buf))
        else $error("commit did not copy staged words");

    chk_active_hold: assert property (
        !commit |=> $stable(q.act) && $stable(q.fr1_act))
        else $error("active words changed without commit");

    chk_lane_guard: assert property (
        (wr_en && q.addr == ddsc_pkg::ADDR_TUNE && !q.csel[ddsc_pkg::CSEL_EN1_BIT])
        |=> $stable(q.stage[1].tune))
        else $error("disabled channel took a tuning write");

    chk_pll_range: assert property (
        ddsc_pkg::mult_valid(q.fr1_act[ddsc_pkg::FR1_MULT_LSB +: 5])
        |=> q.clk.pll_en && q.clk.mult == $past(q.fr1_act[ddsc_pkg::FR1_MULT_LSB +: 5]))
        else $error("multiplier in range but PLL not enabled");

    chk_pll_bypass: assert property (
        !ddsc_pkg::mult_valid(q.fr1_act[ddsc_pkg::FR1_MULT_LSB +: 5])
        |=> !q.clk.pll_en && q.clk.mult == ddsc_pkg::MULT_ONE)
        else $error("multiplier out of range but not bypassed");

    chk_matched_lat: assert property (
        q.match[0] [*6] |-> phase_offset_word_out[0] == $past(q.act[0].phase, 4)
                         && tuning_word_out[0] == $past(q.act[0].tune, 4))
        else $error("matched latency not equal");

    chk_xtal_follow: assert property (
        clk_mode_sel [*4] |-> clk_cfg.xtal_en)
        else $error("crystal enable does not follow mode pin");

    chk_phase_lane: assert property (
        (wr_en && q.addr == ddsc_pkg::ADDR_PHASE && !q.csel[ddsc_pkg::CSEL_EN0_BIT])
        |=> $stable(q.stage[0].phase))
        else $error("disabled channel took a phase write");

    chk_sync_gated: assert property (
        !q.clk.sync_en |=> !sync_clk)
        else $error("sync clock ran while disabled");

    chk_read_drive: assert property (
        q.sdo_oe |-> q.rd)
        else $error("serial data driven outside a read");

    cover_pll_locked: cover property (q.clk.pll_en && q.clk.pll_locked);
    cover_split_words: cover property (commit && q.stage[0].tune != q.stage[1].tune);
    cover_matched: cover property (q.match[0]);
    cover_read_out: cover property (q.sdo_oe);

endmodule // ddsc_mode_clk_cfg

// >>> design/ddsc_pkg.sv
package ddsc_pkg;

    // Register addresses
    localparam logic [4:0] ADDR_CSEL  = 5'h00;
    localparam logic [4:0] ADDR_FR1   = 5'h01;
    localparam logic [4:0] ADDR_CFR   = 5'h03;
    localparam logic [4:0] ADDR_TUNE  = 5'h04;
    localparam logic [4:0] ADDR_PHASE = 5'h05;

    // Channel select fields
    localparam int          CSEL_EN0_BIT  = 6;
    localparam int          CSEL_EN1_BIT  = 7;
    localparam int          CSEL_MODE_LSB = 1;
    localparam logic [7:0]  CSEL_RST      = 8'hC0;

    // Function register one fields
    localparam int          FR1_VCO_BIT      = 23;
    localparam int          FR1_MULT_LSB     = 18;
    localparam int          FR1_CP_LSB       = 16;
    localparam int          FR1_SYNC_DIS_BIT = 5;
    localparam logic [23:0] FR1_RST          = 24'h000000;

    // Channel function fields
    localparam int          CFR_AFP_LSB   = 22;
    localparam int          CFR_SWEEP_BIT = 14;
    localparam int          CFR_DAC_LSB   = 8;
    localparam int          CFR_MATCH_BIT = 5;
    localparam logic [23:0] CFR_RST       = 24'h000300;
    localparam logic [31:0] TUNE_RST      = 32'h00000000;
    localparam logic [15:0] PHASE_RST     = 16'h0000;

    // Multiplier limits
    localparam logic [4:0]  MULT_MIN = 5'h04;
    localparam logic [4:0]  MULT_MAX = 5'h14;
    localparam logic [4:0]  MULT_ONE = 5'h01;

    // Timing
    localparam int          SYS_CLK_MHZ  = 200;
    localparam int          PLL_LOCK_US  = 1000;
    localparam int          PLL_LOCK_CYC = PLL_LOCK_US * SYS_CLK_MHZ;
    localparam int          SYNC_DIV     = 4;
    localparam int          PIPE_DEPTH   = 4;
    localparam logic [1:0]  FREQ_TAP     = 2'h2;
    localparam logic [1:0]  PHASE_TAP    = 2'h0;
    localparam logic [5:0]  INSTR_BITS   = 6'h08;

    // Pin sample positions
    localparam int PIN_CS   = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_SDI  = 2;
    localparam int PIN_UPD  = 3;
    localparam int PIN_CMS  = 4;

    typedef enum logic [1:0] {
        SP_INSTR = 2'b00,
        SP_DATA  = 2'b01,
        SP_SKIP  = 2'b10
    } ddsc_spi_e;

    typedef struct packed {
        logic [23:0] channel_function_reg;
        logic [31:0] tune;
        logic [15:0] phase;
    } ddsc_chan_s;

    typedef struct packed {
        logic       pll_en;
        logic [4:0] mult;
        logic       vco_high;
        logic [1:0] cp_sel;
        logic       xtal_en;
        logic       sync_en;
        logic       pll_locked;
    } ddsc_clk_s;

    localparam ddsc_chan_s CHAN_RST = '{channel_function_reg: CFR_RST, tune: TUNE_RST, phase: PHASE_RST};

    function automatic logic [2:0] reg_bytes(input logic [4:0] a);
        case (a)
            ADDR_CSEL:  reg_bytes = 3'h1;
            ADDR_FR1:   reg_bytes = 3'h3;
            ADDR_CFR:   reg_bytes = 3'h3;
            ADDR_TUNE:  reg_bytes = 3'h4;
            ADDR_PHASE: reg_bytes = 3'h2;
            default:    reg_bytes = 3'h0;
        endcase
    endfunction

    function automatic logic mult_valid(input logic [4:0] m);
        mult_valid = (m >= MULT_MIN) && (m <= MULT_MAX);
    endfunction

endpackage

// >>> design/ddsc_delay_line.sv
`timescale 1ns/1ps
module ddsc_delay_line #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    // Data
    input  wire logic [W-1:0] din,
    input  wire logic [1:0]   tap,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [ddsc_pkg::PIPE_DEPTH-1:0][W-1:0] sh;
        logic [W-1:0]                           q;
    } ddsc_dl_s;

    ddsc_dl_s q;
    ddsc_dl_s d;

    always_comb begin
        d = q;
        d.sh = {q.sh[ddsc_pkg::PIPE_DEPTH-2:0], din};
        d.q  = q.sh[tap];
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.q;

endmodule // ddsc_delay_line

// >>> design/ddsc_sync_gen.sv
`timescale 1ns/1ps
module ddsc_sync_gen (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Control
    input  wire logic sync_en,
    input  wire logic upd_lvl,
    // Outputs
    output logic      sync_clk,
    output logic      commit
);
    typedef struct packed {
        logic [1:0] cnt;
        logic       sclk;
        logic       tick;
        logic       upd_prev;
        logic       commit;
    } ddsc_sg_s;

    ddsc_sg_s q;
    ddsc_sg_s d;

    always_comb begin
        d = q;
        d.cnt    = q.cnt + 2'h1;
        d.sclk   = sync_en & d.cnt[1];
        d.tick   = (q.cnt == 2'(ddsc_pkg::SYNC_DIV - 1));
        d.commit = 1'b0;
        if (q.tick) begin
            d.upd_prev = upd_lvl;
            d.commit   = upd_lvl & ~q.upd_prev;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_clk = q.sclk;
    assign commit   = q.commit;

    chk_sync_period: assert property (@(posedge clk_sys) disable iff (!nrst)
        q.tick |=> !q.tick [*3] ##1 q.tick)
        else $error("sync tick not every fourth cycle");

    cover_commit: cover property (@(posedge clk_sys) disable iff (!nrst) q.commit);

endmodule // ddsc_sync_gen

// >>> bench/ddsc_host_model.sv
`timescale 1ns/1ps
module ddsc_host_model #(
    parameter int HALF = 4
) (
    // Clock
    input  wire logic clk_sys,
    // Serial pins
    output logic      spi_cs_n,
    output logic      spi_sclk,
    output logic      spi_sdio0_i,
    input  wire logic spi_sdio0_o,
    input  wire logic spi_sdio0_oe,
    // Strobe
    output logic      io_update
);
    initial begin
        spi_cs_n    = 1'b1;
        spi_sclk    = 1'b0;
        spi_sdio0_i = 1'b0;
        io_update   = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Frame: instruction then nb bytes, MSB first; read bits taken before each rise
    task automatic xfer(input logic rw, input logic [4:0] a, input logic [31:0] d,
                        input int nb, output logic [31:0] v);
        logic [39:0] f;
        f = {rw, 2'h0, a, d << (32 - 8 * nb)};
        v = 32'h00000000;
        tick(1);
        spi_cs_n = 1'b0;
        for (int i = 39; i >= 32 - 8 * nb; i--) begin
            spi_sdio0_i = f[i];
            tick(HALF);
            // Undriven line reads as the inverse of its last value
            if (i < 32) begin
                v = {v[30:0], spi_sdio0_oe ? spi_sdio0_o : ~spi_sdio0_o};
            end
            spi_sclk = 1'b1;
            tick(HALF);
            spi_sclk = 1'b0;
        end
        tick(HALF);
        spi_cs_n = 1'b1;
        // Released line shows no stale bit
        spi_sdio0_i = ~spi_sdio0_i;
        tick(HALF);
    endtask

    // Write frame, read bits ignored
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input int nb);
        logic [31:0] v;
        xfer(1'b0, a, d, nb, v);
    endtask

    // Strobe held two sync periods
    task automatic commit();
        tick(1);
        io_update = 1'b1;
        tick(8);
        io_update = 1'b0;
        tick(16);
    endtask
endmodule // ddsc_host_model

// >>> bench/tb_ddsc_mode_clk_cfg.sv
`timescale 1ns/1ps
module tb_ddsc_mode_clk_cfg;
    localparam int LOCK = 20;
    logic                clk_sys;
    logic                nrst;
    logic                cs_n;
    logic                sclk;
    logic                sdi;
    logic                upd;
    logic                cms;
    logic                sync_clk;
    logic                sdo;
    logic                sdo_oe;
    logic [1:0][31:0]    tw;
    logic [1:0][15:0]    pw;
    logic [1:0][1:0]     dac;
    logic [1:0]          st;
    logic [1:0]          md;
    logic [1:0]          smode;
    ddsc_pkg::ddsc_clk_s cc;
    int                  n_mismatch;
    int                  samples_checked;

    initial clk_sys = 1'b0;
    always #2.5 clk_sys = ~clk_sys;

    ddsc_host_model host (
        .clk_sys      (clk_sys),
        .spi_cs_n     (cs_n),
        .spi_sclk     (sclk),
        .spi_sdio0_i  (sdi),
        .spi_sdio0_o  (sdo),
        .spi_sdio0_oe (sdo_oe),
        .io_update    (upd)
    );

    ddsc_mode_clk_cfg #(.LOCK_CYC(LOCK)) dut (
        .clk_sys               (clk_sys),
        .nrst                  (nrst),
        .spi_cs_n              (cs_n),
        .spi_sclk              (sclk),
        .spi_sdio0_i           (sdi),
        .spi_sdio0_o           (sdo),
        .spi_sdio0_oe          (sdo_oe),
        .io_update             (upd),
        .clk_mode_sel          (cms),
        .sync_clk              (sync_clk),
        .tuning_word_out       (tw),
        .phase_offset_word_out (pw),
        .dac_scale             (dac),
        .single_tone           (st),
        .matched_delay         (md),
        .serial_mode           (smode),
        .clk_cfg               (cc)
    );

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic t_reset();
        cmp(tw, 64'h0);
        cmp({pw, smode}, 34'h0);
        cmp({dac, st, md}, 8'hFC);
        cmp(cc, 12'h043);
    endtask

    task automatic t_shared();
        host.wr(ddsc_pkg::ADDR_TUNE, 32'h12345678, 4);
        repeat (12) @(posedge clk_sys);
        cmp(tw, 64'h0);
        host.commit();
        cmp(tw, {2{32'h12345678}});
    endtask

    // Each channel programmed alone, one commit at the end
    task automatic t_per_chan();
        logic [31:0] v;
        host.wr(ddsc_pkg::ADDR_CSEL, 32'h40, 1);
        host.wr(5'h02, 32'hA5, 1);
        host.wr(ddsc_pkg::ADDR_TUNE, 32'h0000AAAA, 4);
        host.wr(ddsc_pkg::ADDR_CSEL, 32'h80, 1);
        host.wr(ddsc_pkg::ADDR_TUNE, 32'h0000BBBB, 4);
        host.wr(ddsc_pkg::ADDR_PHASE, 32'h1234, 2);
        host.commit();
        cmp(tw, {32'h0000BBBB, 32'h0000AAAA});
        cmp(pw, {16'h1234, 16'h0000});
        // Reads follow channel one while its enable alone is set
        host.xfer(1'b1, ddsc_pkg::ADDR_TUNE, 32'h00000000, 4, v);
        cmp(v, 32'h0000BBBB);
        host.xfer(1'b1, ddsc_pkg::ADDR_CSEL, 32'h00000000, 1, v);
        cmp(v, 32'h00000080);
    endtask

    task automatic t_cfr();
        host.wr(ddsc_pkg::ADDR_CSEL, 32'h40, 1);
        host.wr(ddsc_pkg::ADDR_CFR, 32'h000120, 3);
        host.commit();
        cmp({dac, st, md}, 8'hDD);
        // Words written while matched land together
        host.wr(ddsc_pkg::ADDR_PHASE, 32'h0DDD, 2);
        host.wr(ddsc_pkg::ADDR_TUNE, 32'h0000CCCC, 4);
        host.commit();
        cmp({tw[0], pw[0]}, {32'h0000CCCC, 16'h0DDD});
        // Other channel stays single-tone
        host.wr(ddsc_pkg::ADDR_CFR, 32'h800120, 3);
        host.commit();
        cmp({st, md}, 4'h8);
        host.wr(ddsc_pkg::ADDR_CFR, 32'h000300, 3);
        host.commit();
        cmp({dac, st}, 6'h3F);
    endtask

    task automatic t_mult();
        logic [4:0] v [4];
        logic       ok;
        v = '{5'h03, 5'h04, 5'h14, 5'h15};
        foreach (v[i]) begin
            ok = (v[i] > 5'h03) && (v[i] < 5'h15);
            host.wr(ddsc_pkg::ADDR_FR1, 32'(v[i]) << 18, 3);
            host.commit();
            for (int k = 0; k < LOCK + 100 && cc.pll_locked !== 1'b1; k++) begin
                @(posedge clk_sys);
                #1;
            end
            if (cc.pll_locked !== 1'b1) begin
                n_mismatch++;
                conclude();
            end
            cmp({cc.pll_en, cc.mult}, {ok, ok ? v[i] : 5'h01});
        end
    endtask

    task automatic t_clk_mode();
        @(posedge clk_sys);
        #1 cms = 1'b1;
        repeat (6) @(posedge clk_sys);
        cmp(cc.xtal_en, 1'b1);
        #1 cms = 1'b0;
        repeat (6) @(posedge clk_sys);
        cmp(cc.xtal_en, 1'b0);
    endtask

    task automatic t_sync(input int exp);
        logic p;
        int   r;
        @(posedge clk_sys);
        #1;
        r = 0;
        p = sync_clk;
        repeat (40) begin
            @(posedge clk_sys);
            #1;
            r += int'(sync_clk === 1'b1 && p === 1'b0);
            p = sync_clk;
        end
        cmp(r, exp);
    endtask

    task automatic do_reset();
        nrst = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 nrst = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask

    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        cms = 1'b0;
        do_reset();
        t_reset();
        t_shared();
        t_per_chan();
        t_cfr();
        // Reset again with words loaded
        do_reset();
        t_reset();
        t_mult();
        t_clk_mode();
        t_sync(10);
        host.wr(ddsc_pkg::ADDR_FR1, 32'h000020, 3);
        host.commit();
        t_sync(0);
        conclude();
    end
endmodule // tb_ddsc_mode_clk_cfg
